// File: logic/rms_pkg.sv
// Purpose: Shared constants for the reading memory store
// Assumes: 32-bit Avalon-MM register bus, word addressed by byte offset
// Notes: Memory holds reading words of 64 bits; encoding fixes bytes used
package rms_pkg;
  // Register byte offsets
  localparam logic [4:0] REG_MODE = 5'h00;
  localparam logic [4:0] REG_ENC = 5'h04;
  localparam logic [4:0] REG_COUNT = 5'h08;
  localparam logic [4:0] REG_DATA_LO = 5'h0c;
  localparam logic [4:0] REG_DATA_HI = 5'h10;
  localparam logic [4:0] REG_CTRL = 5'h14;
  localparam logic [4:0] REG_STATUS = 5'h18;
  // Storage mode codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_LIFO = 2'h1;
  localparam logic [1:0] MODE_FIFO = 2'h2;
  localparam logic [1:0] MODE_RESUME = 2'h3;
  // Storage encoding codes
  localparam logic [2:0] ENC_TEXT = 3'h1;
  localparam logic [2:0] ENC_SHORT = 3'h2;
  localparam logic [2:0] ENC_LONG = 3'h3;
  localparam logic [2:0] ENC_SINGLE = 3'h4;
  localparam logic [2:0] ENC_DOUBLE = 3'h5;
  // Bytes per stored reading
  localparam logic [4:0] BYTES_TEXT = 5'h10;
  localparam logic [4:0] BYTES_SHORT = 5'h02;
  localparam logic [4:0] BYTES_LONG = 5'h04;
  localparam logic [4:0] BYTES_SINGLE = 5'h04;
  localparam logic [4:0] BYTES_DOUBLE = 5'h08;
  // Reset values
  localparam logic [1:0] RESET_MODE = MODE_OFF;
  localparam logic [2:0] RESET_ENC = ENC_SINGLE;
  // Memory size
  localparam int DEPTH = 256;
  localparam int AW = 8;
  localparam int DW = 64;
  // Control register bits
  localparam int CTRL_HIGH_SPEED = 0;
  localparam int CTRL_RECALL = 1;
  localparam int CTRL_SUBSAMPLED = 2;
  localparam int CTRL_ARM_FREE = 3;
  // Status register bits
  localparam int STAT_ARM_HOLD = 0;
  localparam int STAT_HIGH_SPEED = 1;
  localparam int STAT_SUBSAMPLE_ERR = 2;
  localparam int STAT_DATA_VALID = 3;
  // Overload marker stored in place of a reading
  localparam logic [DW-1:0] OVERLOAD_WORD = 64'h47d2ced32a16a1b1;
endpackage

// File: logic/rms_mem.sv
// Purpose: Single-port-write, registered-read reading memory
// Assumes: One clock; read data valid the cycle after the read strobe
// Notes: Contents are not cleared; emptiness is kept by the reading count in rms_top
`timescale 1ns/1ps
`default_nettype none
module rms_mem
  import rms_pkg::*;
(
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// File: logic/rms_fmt.sv
// Purpose: Fit a reading word to the storage encoding width
// Assumes: Reading arrives as a 64-bit word already in the encoding
// Notes: Overload flag replaces the reading with the overload marker
`timescale 1ns/1ps
`default_nettype none
module rms_fmt
  import rms_pkg::*;
(
  // Select
  input wire logic [2:0] enc,
  // Reading
  input wire logic [DW-1:0] raw,
  input wire logic overload,
  output logic [DW-1:0] stored
);
  always_comb begin
    stored = raw;
    if (overload) begin
      stored = OVERLOAD_WORD;
    end else begin
      unique case (enc)
        ENC_SHORT: stored = {48'h0, raw[15:0]};
        ENC_LONG: stored = {32'h0, raw[31:0]};
        ENC_SINGLE: stored = {32'h0, raw[31:0]};
        ENC_TEXT: stored = {raw[63:8], 8'h00};
        default: stored = raw;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: logic/rms_top.sv
// What this block does
// - Mode off stops storing, keeps contents
// - Last-in or first-in selection empties memory
// - Resume keeps contents, restores prior order
// - High-speed full first-in holds arming, exits
// - Normal full first-in discards new readings
// - Full last-in overwrites oldest entry
// - Empty output read removes one reading
// - Last-in returns newest, first-in oldest
// - Bulk recall ignores storage order
// - Bulk recall turns storage mode off
// - Count query returns readings held
// - Encoding change empties memory
// - Short and long integers take 2, 4 bytes
// - Single, double floats take 4, 8 bytes
// - Text takes 16 bytes, null terminated
// - Overload stored as the overload marker
// - Overload translated to output encoding code
// - Integer recall rescaled by present factor
// - Sub-sampling needs short, first-in, empty memory
// - Storage encoding never steers output encoding
//
// Purpose: Reading memory with first-in or last-in order over Avalon-MM
// Assumes: Readings arrive as one-cycle strobes; scale and overload code given
// Notes: Recall rescaling multiplies the stored integer by SCALE_FACTOR input
`timescale 1ns/1ps
`default_nettype none
module rms_top
  import rms_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Avalon-MM slave
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Measurement front end
  input wire logic READING_VALID,
  input wire logic [DW-1:0] READING_DATA,
  input wire logic READING_OVERLOAD,
  input wire logic ARM_EVENT,
  // Recall configuration
  input wire logic [31:0] SCALE_FACTOR,
  input wire logic [DW-1:0] OUT_OVERLOAD_CODE,
  // Status outputs
  output logic ARM_HOLD,
  output logic HIGH_SPEED_ACTIVE,
  output logic SUBSAMPLE_ERROR
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_DONE = 3'b100
  } rms_state_t;

  rms_state_t state, next_state;
  logic [1:0] mode, next_mode, prev_order, next_prev_order;
  logic [2:0] enc, next_enc;
  logic [AW-1:0] head, next_head, tail, next_tail;
  logic [AW:0] count, next_count;
  logic [DW-1:0] out_word, next_out_word;
  logic out_valid, next_out_valid;
  logic hs, next_hs, hold, next_hold, sub_err, next_sub_err;
  logic recall_flag, next_recall_flag;
  logic [31:0] rdata, next_rdata;
  logic wait_rq, next_wait_rq;
  logic [DW-1:0] stored;
  logic mem_wr, mem_rd;
  logic [AW-1:0] wr_addr, rd_addr;
  logic [DW-1:0] mem_q;
  logic full, empty, bus_wr, bus_rd, take_read;
  logic [63:0] scaled;
  logic signed [31:0] rec_int;

  rms_fmt u_fmt (
    .enc(enc),
    .raw(READING_DATA),
    .overload(READING_OVERLOAD),
    .stored(stored)
  );

  rms_mem u_mem (
    .clk(CLK),
    .wr_en(mem_wr),
    .wr_addr(wr_addr),
    .wr_data(stored),
    .rd_en(mem_rd),
    .rd_addr(rd_addr),
    .rd_data(mem_q)
  );

  assign full = (count == (AW+1)'(DEPTH));
  assign empty = (count == '0);
  assign bus_wr = AVS_WRITE && wait_rq;
  assign bus_rd = AVS_READ && wait_rq;
  // Implied read: host reads data while nothing is staged for it
  // An empty memory or a stopped store answers as a plain register read
  assign take_read = bus_rd && (AVS_ADDRESS == REG_DATA_LO) && !out_valid
                     && state == ST_IDLE && !empty && (mode == MODE_FIFO || mode == MODE_LIFO);
  // Short integers are sign extended from 16 bits before rescaling
  assign rec_int = (enc == ENC_SHORT) ? 32'($signed(mem_q[15:0])) : mem_q[31:0];
  assign scaled = 64'(rec_int * $signed(SCALE_FACTOR));

  always_comb begin
    next_state = state;
    next_mode = mode;
    next_prev_order = prev_order;
    next_enc = enc;
    next_head = head;
    next_tail = tail;
    next_count = count;
    next_out_word = out_word;
    next_out_valid = out_valid;
    next_hs = hs;
    next_hold = hold;
    next_sub_err = sub_err;
    next_recall_flag = recall_flag;
    next_rdata = rdata;
    next_wait_rq = 1'b1;
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    wr_addr = head;
    rd_addr = tail;

    // Store path; head is the next free slot, tail the oldest entry
    if (READING_VALID && !hold && (mode == MODE_FIFO || mode == MODE_LIFO)) begin
      if (!full) begin
        mem_wr = 1'b1;
        next_head = head + 1'b1;
        next_count = count + 1'b1;
      end else if (mode == MODE_LIFO) begin
        mem_wr = 1'b1;
        next_head = head + 1'b1;
        next_tail = tail + 1'b1;
      end else if (hs) begin
        next_hold = 1'b1;
        next_hs = 1'b0;
      end
      // Full first-in outside high speed drops the reading
    end

    unique case (state)
      ST_IDLE: begin
        if (take_read) begin
          mem_rd = 1'b1;
          if (mode == MODE_LIFO) begin
            rd_addr = head - 1'b1;
            next_head = head - 1'b1;
          end else begin
            next_tail = tail + 1'b1;
          end
          next_count = count - 1'b1;
          next_state = ST_FETCH;
        end else if (bus_rd || bus_wr) begin
          next_wait_rq = 1'b0;
          next_state = ST_DONE;
        end
      end
      ST_FETCH: begin
        // Overload leaves in the output encoding's own code
        if (mem_q == OVERLOAD_WORD) begin
          next_out_word = OUT_OVERLOAD_CODE;
        end else if (enc == ENC_SHORT || enc == ENC_LONG) begin
          next_out_word = scaled;
        end else begin
          next_out_word = mem_q;
        end
        next_out_valid = 1'b1;
        next_state = ST_IDLE;
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
    endcase

    if (state == ST_IDLE && bus_rd && !take_read) begin
      unique case (AVS_ADDRESS)
        REG_MODE: next_rdata = {30'h0, mode};
        REG_ENC: next_rdata = {29'h0, enc};
        REG_COUNT: next_rdata = {23'h0, count};
        REG_DATA_LO: next_rdata = out_word[31:0];
        REG_DATA_HI: begin
          next_rdata = out_word[63:32];
          next_out_valid = 1'b0;
        end
        REG_STATUS: next_rdata = {28'h0, out_valid, sub_err, hs, hold};
        default: next_rdata = 32'h0;
      endcase
    end else if (state == ST_FETCH) begin
      next_rdata = next_out_word[31:0];
      next_wait_rq = 1'b0;
      next_state = ST_DONE;
    end

    // Writes land on the edge at which the master sees waitrequest low
    if (state == ST_DONE && AVS_WRITE) begin
      unique case (AVS_ADDRESS)
        REG_MODE: begin
          unique case (AVS_WRITEDATA[1:0])
            MODE_OFF: next_mode = MODE_OFF;
            MODE_RESUME: begin
              next_mode = (prev_order == MODE_OFF) ? MODE_FIFO : prev_order;
              next_prev_order = next_mode;
            end
            default: begin
              next_mode = AVS_WRITEDATA[1:0];
              next_prev_order = AVS_WRITEDATA[1:0];
              next_head = '0;
              next_tail = '0;
              next_count = '0;
              next_out_valid = 1'b0;
              next_sub_err = 1'b0;
            end
          endcase
        end
        REG_ENC: begin
          if (AVS_WRITEDATA[2:0] >= ENC_TEXT && AVS_WRITEDATA[2:0] <= ENC_DOUBLE) begin
            next_enc = AVS_WRITEDATA[2:0];
            next_head = '0;
            next_tail = '0;
            next_count = '0;
          end
        end
        REG_CTRL: begin
          next_hs = AVS_WRITEDATA[CTRL_HIGH_SPEED];
          next_recall_flag = !AVS_WRITEDATA[CTRL_SUBSAMPLED];
          if (AVS_WRITEDATA[CTRL_ARM_FREE]) begin
            // A hold raised by an overflow in this same cycle outlives the release
            next_hold = next_hold && !hold;
          end
          if (AVS_WRITEDATA[CTRL_RECALL]) begin
            next_mode = MODE_OFF;
            next_out_valid = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Placed after the writes so an error at arming outlives a same-cycle clear
    if (ARM_EVENT && recall_flag == 1'b0 && hs_sub_needed()) begin
      next_sub_err = 1'b1;
    end
  end

  // Sub-sampling demands short integers, first-in order and an empty memory
  function automatic logic hs_sub_needed();
    return !(enc == ENC_SHORT && mode == MODE_FIFO && empty);
  endfunction

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
      mode <= RESET_MODE;
      prev_order <= MODE_OFF;
      enc <= RESET_ENC;
      head <= '0;
      tail <= '0;
      count <= '0;
      out_word <= '0;
      out_valid <= 1'b0;
      hs <= 1'b0;
      hold <= 1'b0;
      sub_err <= 1'b0;
      recall_flag <= 1'b1;
      rdata <= '0;
      wait_rq <= 1'b1;
    end else begin
      state <= next_state;
      mode <= next_mode;
      prev_order <= next_prev_order;
      enc <= next_enc;
      head <= next_head;
      tail <= next_tail;
      count <= next_count;
      out_word <= next_out_word;
      out_valid <= next_out_valid;
      hs <= next_hs;
      hold <= next_hold;
      sub_err <= next_sub_err;
      recall_flag <= next_recall_flag;
      rdata <= next_rdata;
      wait_rq <= next_wait_rq;
    end
  end

  assign AVS_READDATA = rdata;
  assign AVS_WAITREQUEST = wait_rq;
  assign ARM_HOLD = hold;
  assign HIGH_SPEED_ACTIVE = hs;
  assign SUBSAMPLE_ERROR = sub_err;

  overflow_hold_a: assert property (@(posedge CLK) disable iff (RST)
    (READING_VALID && full && hs && !hold && mode == MODE_FIFO && !AVS_WRITE && !take_read)
    |=> (hold && !hs && count == (AW+1)'(DEPTH)))
    else $error("full high-speed store did not hold");
  discard_full_a: assert property (@(posedge CLK) disable iff (RST)
    (READING_VALID && full && !hs && mode == MODE_FIFO && state == ST_IDLE && !AVS_READ
     && !AVS_WRITE) |=> $stable(head) && $stable(count))
    else $error("full store altered memory");
  lifo_overwrite_a: assert property (@(posedge CLK) disable iff (RST)
    (READING_VALID && full && mode == MODE_LIFO && !hold && !AVS_READ && !AVS_WRITE)
    |=> count == (AW+1)'(DEPTH) && tail == $past(tail) + 1'b1)
    else $error("last-in overwrite wrong");
  mode_off_a: assert property (@(posedge CLK) disable iff (RST)
    (mode == MODE_OFF && READING_VALID) |-> !mem_wr)
    else $error("reading stored while off");
  implied_read_a: assert property (@(posedge CLK) disable iff (RST)
    (take_read && !empty && mode != MODE_OFF && mode != MODE_RESUME && !READING_VALID)
    |=> count == $past(count) - 1'b1 ##1 !AVS_WAITREQUEST && out_valid)
    else $error("implied read not served");
  recall_off_a: assert property (@(posedge CLK) disable iff (RST)
    (AVS_WRITE && state == ST_DONE && AVS_ADDRESS == REG_CTRL && AVS_WRITEDATA[CTRL_RECALL])
    |=> mode == MODE_OFF)
    else $error("bulk recall left storage on");
  enc_clear_a: assert property (@(posedge CLK) disable iff (RST)
    (AVS_WRITE && state == ST_DONE && AVS_ADDRESS == REG_ENC && AVS_WRITEDATA[2:0] == ENC_SHORT)
    |=> count == '0 && enc == ENC_SHORT)
    else $error("encoding change kept readings");
  order_clear_a: assert property (@(posedge CLK) disable iff (RST)
    (AVS_WRITE && state == ST_DONE && AVS_ADDRESS == REG_MODE && !ARM_EVENT
     && (AVS_WRITEDATA[1:0] == MODE_FIFO || AVS_WRITEDATA[1:0] == MODE_LIFO))
    |=> count == '0 && !SUBSAMPLE_ERROR && (mode == MODE_FIFO || mode == MODE_LIFO))
    else $error("order select kept readings");
  resume_keep_a: assert property (@(posedge CLK) disable iff (RST)
    (AVS_WRITE && state == ST_DONE && AVS_ADDRESS == REG_MODE && !READING_VALID
     && AVS_WRITEDATA[1:0] == MODE_RESUME)
    |=> $stable(count) && (mode == MODE_FIFO || mode == MODE_LIFO))
    else $error("resume lost readings");
  arm_error_a: assert property (@(posedge CLK) disable iff (RST)
    (ARM_EVENT && !recall_flag && !(enc == ENC_SHORT && mode == MODE_FIFO && empty))
    |=> SUBSAMPLE_ERROR)
    else $error("sub-sampling error not raised");
  bus_answer_a: assert property (@(posedge CLK) disable iff (RST)
    (state == ST_IDLE && AVS_READ && AVS_ADDRESS == REG_COUNT && wait_rq)
    |=> !AVS_WAITREQUEST && AVS_READDATA == 32'($past(count)))
    else $error("count query wrong");
endmodule
`default_nettype wire

// File: verif/rms_host.sv
// Purpose: Host controller model, an Avalon-MM master facing the reading store
// Assumes: Requests start just after a rising edge and hold until waitrequest low
// Notes: Waits are bounded; ok low tells the caller the slave never answered
`timescale 1ns/1ps
`default_nettype none
module rms_host (
  // Clock
  input wire logic clk,
  // Avalon-MM master
  output logic [4:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  initial begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    ok = (waitrequest === 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // Released lines show the inverse so a stale value is never trusted
    address <= ~a;
    writedata <= ~d;
  endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Purpose: Self-checking bench for the reading memory store
// Assumes: Float and integer encodings for data checks; text is never stored
// Notes: A queue model mirrors the store and is compared at every result
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  import rms_pkg::*;
  logic clk, rst, valid, ovl, arm, wrq, rrq, waitreq;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, scale, q;
  logic [DW-1:0] rdg, ovcode;
  logic [64:0] mq[$];
  logic [1:0] mm, prev_order;
  logic [2:0] me;
  logic ahold, hsa, serr, hsm, held;
  int fails, tests_run, e;

  rms_top DUT (.CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rrq), .AVS_WRITE(wrq),
    .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .READING_VALID(valid), .READING_DATA(rdg), .READING_OVERLOAD(ovl), .ARM_EVENT(arm),
    .SCALE_FACTOR(scale), .OUT_OVERLOAD_CODE(ovcode), .ARM_HOLD(ahold),
    .HIGH_SPEED_ACTIVE(hsa), .SUBSAMPLE_ERROR(serr));
  rms_host host (.clk(clk), .address(addr), .read(rrq), .write(wrq), .writedata(wdata),
    .readdata(rdata), .waitrequest(waitreq));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    logic ok;
    host.xfer(wr, a, d, q, ok);
    if (!ok) begin
      fails++;
      test_done();
    end
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask

  task automatic cnt();
    rchk(REG_COUNT, 32'(mq.size()));
  endtask

  task automatic setmode(input logic [1:0] c);
    bus(1'b1, REG_MODE, {30'h0, c});
    if (c == MODE_OFF) begin
      mm = MODE_OFF;
    end else if (c == MODE_RESUME) begin
      mm = (prev_order == MODE_OFF) ? MODE_FIFO : prev_order;
    end else begin
      mq.delete();
      mm = c;
      prev_order = c;
    end
  endtask

  task automatic setenc(input logic [2:0] c);
    bus(1'b1, REG_ENC, {29'h0, c});
    mq.delete();
    me = c;
  endtask

  task automatic arm_pulse();
    @(posedge clk);
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
  endtask

  // Recalled word: overload code, rescaled integer or the stored float
  function automatic logic [63:0] recalled(input logic [64:0] m);
    logic [63:0] r;
    r = m[63:0];
    if (m[64]) begin
      r = ovcode;
    end else if (me == ENC_SHORT) begin
      r = 64'($signed(m[15:0]) * $signed(scale));
    end else if (me == ENC_LONG) begin
      r = 64'($signed(m[31:0]) * $signed(scale));
    end else if (me == ENC_SINGLE) begin
      r = {32'h0, m[31:0]};
    end
    return r;
  endfunction

  task automatic put(input logic o);
    logic [63:0] v;
    v = {$urandom, $urandom};
    @(posedge clk);
    valid <= 1'b1;
    rdg <= v;
    ovl <= o;
    @(posedge clk);
    valid <= 1'b0;
    rdg <= ~v;
    ovl <= 1'b0;
    if (mm == MODE_LIFO) begin
      if (mq.size() == DEPTH) begin
        void'(mq.pop_front());
      end
      mq.push_back({o, v});
    end else if (mm == MODE_FIFO && mq.size() < DEPTH && !held) begin
      mq.push_back({o, v});
    end else if (mm == MODE_FIFO && hsm) begin
      // High-speed overflow parks arming in hold and drops high speed
      held = 1'b1;
      hsm = 1'b0;
    end
  endtask

  // Implied read: low word first, high word releases the staged entry
  task automatic pop();
    logic [31:0] lo;
    logic [64:0] m;
    bus(1'b0, REG_DATA_LO, 32'h0);
    lo = q;
    bus(1'b0, REG_DATA_HI, 32'h0);
    m = (mm == MODE_LIFO) ? mq.pop_back() : mq.pop_front();
    `CHK({q, lo}, recalled(m))
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    void'($urandom(32'ha645ed61));
    rst = 1'b1;
    valid = 1'b0;
    ovl = 1'b0;
    arm = 1'b0;
    rdg = '0;
    scale = $urandom;
    ovcode = {$urandom, $urandom};
    mm = MODE_OFF;
    prev_order = MODE_OFF;
    me = RESET_ENC;
    hsm = 1'b0;
    held = 1'b0;
    fails = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rchk(REG_MODE, 32'h0);
    rchk(REG_ENC, {29'h0, RESET_ENC});
    cnt();
    rchk(5'h1c, 32'h0);
    for (e = 1; e <= 5; e++) begin
      setenc(3'(e));
      rchk(REG_ENC, 32'(e));
    end
    bus(1'b1, REG_ENC, 32'h7);
    rchk(REG_ENC, {29'h0, ENC_DOUBLE});
    // Readings carry no frequency, range or math context, so integers stay safe
    setmode(MODE_FIFO);
    put(1'b0);
    put(1'b1);
    put(1'b0);
    cnt();
    pop();
    setmode(MODE_OFF);
    put(1'b0);
    put(1'b0);
    cnt();
    setmode(MODE_RESUME);
    pop();
    cnt();
    setmode(MODE_LIFO);
    cnt();
    repeat (3) put(1'b0);
    pop();
    setmode(MODE_OFF);
    setmode(MODE_RESUME);
    put(1'b0);
    pop();
    cnt();
    repeat (DEPTH + 2) put(1'b0);
    cnt();
    pop();
    setmode(MODE_FIFO);
    repeat (DEPTH + 2) put(1'b0);
    cnt();
    pop();
    setenc(ENC_LONG);
    cnt();
    setenc(ENC_DOUBLE);
    setmode(MODE_FIFO);
    put(1'b0);
    put(1'b0);
    bus(1'b1, REG_CTRL, 32'h1 << CTRL_RECALL);
    mm = MODE_OFF;
    rchk(REG_MODE, 32'h0);
    put(1'b0);
    cnt();
    setmode(MODE_RESUME);
    put(1'b0);
    cnt();
    pop();
    // High-speed first-in overflow parks the arming event in hold
    setmode(MODE_FIFO);
    bus(1'b1, REG_CTRL, 32'h1 << CTRL_HIGH_SPEED);
    hsm = 1'b1;
    rchk(REG_STATUS, 32'h2);
    `CHK(hsa, 1'b1)
    repeat (DEPTH + 1) put(1'b0);
    pop();
    put(1'b0);
    cnt();
    `CHK({ahold, hsa}, 2'b10)
    bus(1'b1, REG_CTRL, 32'h1 << CTRL_ARM_FREE);
    held = 1'b0;
    put(1'b0);
    cnt();
    `CHK(ahold, 1'b0)
    // Sub-sampling with the wrong encoding is refused at the arming event
    bus(1'b1, REG_CTRL, 32'h1 << CTRL_SUBSAMPLED);
    arm_pulse();
    rchk(REG_STATUS, 32'h4);
    `CHK(serr, 1'b1)
    setenc(ENC_SHORT);
    setmode(MODE_FIFO);
    arm_pulse();
    rchk(REG_STATUS, 32'h0);
    `CHK(serr, 1'b0)
    put(1'b0);
    put(1'b1);
    pop();
    pop();
    setenc(ENC_LONG);
    setmode(MODE_FIFO);
    put(1'b0);
    pop();
    cnt();
    test_done();
  end
endmodule
`default_nettype wire
